// ### design/clk_switch_pkg.sv
// constants, field layout and helper functions of the oscillator switch controller
// assumes a 16-bit register port with four word addresses
package clk_switch_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 2;

    // register word addresses
    localparam logic [1:0] ADDR_OSC_HI = 2'h0;
    localparam logic [1:0] ADDR_OSC_LO = 2'h1;
    localparam logic [1:0] ADDR_ACLK   = 2'h2;
    localparam logic [1:0] ADDR_KEY    = 2'h3;

    // unlock key words, values arbitrary
    localparam logic [15:0] KEY_FIRST  = 16'h5A5A;
    localparam logic [15:0] KEY_SECOND = 16'hA5A5;

    // oscillator control word fields
    localparam int unsigned CUR_LSB    = 12;
    localparam int unsigned NEW_LSB    = 8;
    localparam int unsigned CLOCK_LOCK_BIT_B  = 7;
    localparam int unsigned PLLLOCK_B  = 5;
    localparam int unsigned CFAIL_B    = 3;
    localparam int unsigned SECEN_B    = 1;
    localparam int unsigned SWREQ_B    = 0;

    // auxiliary clock control fields
    localparam int unsigned AUX_SRC_B  = 13;
    localparam int unsigned AUX_TYPE_L = 11;
    localparam int unsigned AUX_DIV_L  = 8;
    localparam int unsigned AUX_REF_B  = 7;
    localparam logic [15:0] ACLK_RESET = 16'h0000;
    localparam logic [1:0]  AUX_OSC_OFF = 2'h0;

    // source encodings
    localparam logic [2:0] SRC_FRC     = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI     = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC     = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSC    = 3'h5;
    localparam logic [2:0] SRC_FRC_16  = 3'h6;
    localparam logic [2:0] SRC_FRC_N   = 3'h7;
    localparam logic [1:0] SUBMODE_EXT = 2'h3;

    // oscillator enable bit positions
    localparam int unsigned OSC_FRC  = 0;
    localparam int unsigned OSC_PRI  = 1;
    localparam int unsigned OSC_SEC  = 2;
    localparam int unsigned OSC_LOW_POWER_RC_OSC = 3;

    // new-clock cycles counted before changeover
    localparam int unsigned SWITCH_WAIT_CYCLES = 10;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_COUNT = 2'b11,
        ST_DONE  = 2'b10
    } sw_state_t;

    // one-hot oscillator that a source code needs running
    function automatic logic [3:0] src_osc(input logic [2:0] s);
        logic [3:0] r;
        r = 4'h0;
        case (s)
            SRC_PRI, SRC_PRI_PLL: r[OSC_PRI]  = 1'b1;
            SRC_SEC:              r[OSC_SEC]  = 1'b1;
            SRC_LOW_POWER_RC_OSC:             r[OSC_LOW_POWER_RC_OSC] = 1'b1;
            default:              r[OSC_FRC]  = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic src_pll(input logic [2:0] s);
        return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
    endfunction

endpackage

// ### design/clk_switch_fail_safe.sv
// oscillator selection, switch sequencer, fail-safe monitor and auxiliary divider setup
// assumes oscillator status lines arrive asynchronously and config bits are static
//
// How it works
// - aux divider source bit picks auxiliary oscillator when set, system PLL clock when clear
// - aux mode: 11 external, 10 XT, 01 HS, 00 disabled by default
// - aux output divide code 111..001 divides 1..64, 000 divides by 256
// - aux reference bit picks primary oscillator when set, auxiliary when clear
// - aux control register resets only on power-on reset
// - software may switch sources but primary submode is fixed after power-on
// - switching and fail-safe work only when switching config bit is 0
// - switching disabled: new field ignored, current field shows startup config
// - switching disabled: switch request bit has no effect, reads 0
// - request with equal current and new fields clears request and aborts
// - valid switch start clears PLL lock status and clock fail flag
// - enable new oscillator, wait crystal timer and PLL lock as needed
// - count 10 new-clock cycles after ready before changing over
// - changeover clears request bit and copies new field into current field
// - old source stops; LOW_POWER_RC_OSC kept for watchdog or monitor, secondary while enabled
// - processor keeps running during switching; block never stalls it
// - fail-safe enabled keeps low-power RC oscillator running outside reset
// - oscillator failure raises a trap pulse and falls back to fast RC
// - failure while on a PLL source falls back to fast RC with PLL
// - new field is writable only while clock lock bit is clear
// - clock lock bit set blocks switching, clear permits it
// - clock fail flag set by monitor, readable and clearable by software
// - source code: 000 FAST_RC_OSC, 001 FAST_RC_OSC PLL, 010 pri, 011 pri PLL, 100 sec, 101 LOW_POWER_RC_OSC
// - PLL lock bit shows PLL locked, zero when unlocked, starting or disabled
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

module clk_switch_fail_safe #(
    parameter int unsigned NEW_CLK_WAIT = clk_switch_pkg::SWITCH_WAIT_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               srst,
    input  wire logic                               por_rst,
    input  wire logic [clk_switch_pkg::ADDR_W-1:0] addr,
    input  wire logic [clk_switch_pkg::DATA_W-1:0] wr_data,
    input  wire logic                               wr_en,
    input  wire logic                               rd_en,
    output logic      [clk_switch_pkg::DATA_W-1:0] rd_data,
    input  wire logic                               switching_config_bit,
    input  wire logic                               fail_safe_monitor_en,
    input  wire logic                               wdt_en,
    input  wire logic [2:0]                         startup_source_config,
    input  wire logic [1:0]                         primary_submode_config,
    input  wire logic                               crystal_startup_timer_done,
    input  wire logic                               pll_locked_in,
    input  wire logic                               osc_fail_in,
    input  wire logic                               new_clk_in,
    output logic      [2:0]                         sys_clk_sel,
    output logic                                    sys_pll_en,
    output logic      [3:0]                         osc_run_en,
    output logic                                    clock_fail_trap,
    output logic      [1:0]                         primary_submode,
    output logic                                    aux_divider_source_sel,
    output logic                                    aux_osc_enable,
    output logic      [1:0]                         aux_osc_type,
    output logic      [3:0]                         aux_div_log2,
    output logic                                    aux_reference_sel
);
    import clk_switch_pkg::*;

    initial begin
        if (NEW_CLK_WAIT < 1 || NEW_CLK_WAIT > 15) begin
            $error("NEW_CLK_WAIT must lie in 1..15");
        end
    end

    localparam logic [3:0] WAIT_LAST = 4'(NEW_CLK_WAIT - 1);

    // two-flop synchronisers: ost, pll lock, failure, new clock
    logic [3:0] sync_a_r;
    logic [3:0] sync_b_r;
    logic       new_clk_d_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                sync_a_r[gi] <= (gi == 0) ? crystal_startup_timer_done :
                                (gi == 1) ? pll_locked_in :
                                (gi == 2) ? osc_fail_in : new_clk_in;
                sync_b_r[gi] <= sync_a_r[gi];
            end
        end
    endgenerate
    logic ost_s, pll_s, fail_s, new_edge;
    assign ost_s    = sync_b_r[0];
    assign pll_s    = sync_b_r[1];
    assign fail_s   = sync_b_r[2];
    assign new_edge = sync_b_r[3] & ~new_clk_d_r;

    // power-on state: control words, current source, flags
    logic [2:0]  new_source_field_r, new_source_field_nxt, cur_r, cur_nxt;
    logic        clock_lock_bit_r, clock_lock_bit_nxt, secen_r, secen_nxt;
    logic        switch_request_bit_r, switch_request_bit_nxt, cf_r, cf_nxt, lock_r, lock_nxt;
    logic [15:0] aclk_r, aclk_nxt;
    logic [1:0]  submode_r;
    // sequencer state
    sw_state_t   state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [1:0]  key_r, key_nxt;
    logic        trap_r, trap_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic [3:0]  oscen_r, oscen_nxt;
    logic        pllen_r, pllen_nxt;
    logic [3:0]  div_r, div_nxt;

    logic sw_off, fail_safe_monitor_on, unlocked, wr_hi, wr_lo, fail_evt, start_evt, redundant;
    logic need_ost, need_pll, ready;
    logic [3:0] cur_osc, new_osc;
    logic aux_en_r, aux_en_nxt;

    // selects are taken from named copies, never from a call result
    assign cur_osc = src_osc(cur_r);
    assign new_osc = src_osc(new_source_field_r);

    assign sw_off   = switching_config_bit;
    assign fail_safe_monitor_on  = ~switching_config_bit & fail_safe_monitor_en;
    assign unlocked = (key_r == 2'h2);
    assign wr_hi    = wr_en && addr == ADDR_OSC_HI && unlocked;
    assign wr_lo    = wr_en && addr == ADDR_OSC_LO && unlocked;
    // a monitor already running on the fast RC has nothing to fall back to
    assign fail_evt = fail_safe_monitor_on && fail_s && !cur_osc[OSC_FRC];
    assign redundant = (new_source_field_r == cur_r);
    assign start_evt = state_r == ST_IDLE && switch_request_bit_r && !sw_off && !clock_lock_bit_r
                       && !redundant && !fail_evt;
    // crystal sources wait for the start-up timer, PLL sources for lock
    assign need_ost = new_osc[OSC_SEC]
                      || (new_osc[OSC_PRI] && submode_r != SUBMODE_EXT);
    assign need_pll = src_pll(new_source_field_r);
    assign ready    = (!need_ost || ost_s) && (!need_pll || pll_s);

    // register-side next values
    always_comb begin
        new_source_field_nxt    = new_source_field_r;
        clock_lock_bit_nxt = clock_lock_bit_r;
        secen_nxt   = secen_r;
        switch_request_bit_nxt   = switch_request_bit_r;
        cf_nxt      = cf_r;
        aclk_nxt    = aclk_r;
        cur_nxt     = cur_r;
        lock_nxt    = pll_s & pllen_r;
        if (wr_hi && !clock_lock_bit_r) begin
            new_source_field_nxt = wr_data[NEW_LSB +: 3];
        end
        if (wr_lo) begin
            clock_lock_bit_nxt = wr_data[CLOCK_LOCK_BIT_B];
            secen_nxt   = wr_data[SECEN_B];
            if (!wr_data[CFAIL_B]) begin
                cf_nxt = 1'b0;
            end
            if (wr_data[SWREQ_B] && !clock_lock_bit_r) begin
                switch_request_bit_nxt = 1'b1;
            end
        end
        if (wr_en && addr == ADDR_ACLK) begin
            aclk_nxt = {2'h0, wr_data[13:7], 7'h00};
        end
        if (state_r == ST_IDLE && switch_request_bit_r && redundant) begin
            switch_request_bit_nxt = 1'b0;
        end
        if (start_evt) begin
            cf_nxt   = 1'b0;
            lock_nxt = 1'b0;
        end
        if (state_r == ST_DONE) begin
            cur_nxt   = new_source_field_r;
            switch_request_bit_nxt = 1'b0;
        end
        // failure wins over both a software clear and a changeover
        if (fail_evt) begin
            cf_nxt    = 1'b1;
            switch_request_bit_nxt = 1'b0;
            cur_nxt   = src_pll(cur_r) ? SRC_FRC_PLL : SRC_FRC;
        end
        if (sw_off) begin
            switch_request_bit_nxt = 1'b0;
            cur_nxt   = startup_source_config;
        end
        aux_en_nxt = (aclk_nxt[AUX_TYPE_L +: 2] != AUX_OSC_OFF);
    end

    // power-on-only registers; a plain reset leaves them alone
    always_ff @(posedge core_clk) begin
        if (por_rst) begin
            new_source_field_r    <= SRC_FRC;
            cur_r     <= SRC_FRC;
            clock_lock_bit_r <= 1'b0;
            secen_r   <= 1'b0;
            switch_request_bit_r   <= 1'b0;
            cf_r      <= 1'b0;
            lock_r    <= 1'b0;
            aclk_r    <= ACLK_RESET;
            aux_en_r  <= 1'b0;
            submode_r <= primary_submode_config;
        end else begin
            new_source_field_r    <= new_source_field_nxt;
            cur_r     <= cur_nxt;
            clock_lock_bit_r <= clock_lock_bit_nxt;
            secen_r   <= secen_nxt;
            switch_request_bit_r   <= switch_request_bit_nxt;
            cf_r      <= cf_nxt;
            lock_r    <= lock_nxt;
            aclk_r    <= aclk_nxt;
            aux_en_r  <= aux_en_nxt;
            submode_r <= submode_r;
        end
    end

    // sequencer, unlock tracking, outputs and read data
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        trap_nxt  = fail_evt;
        // any write other than the expected key word drops the unlock
        key_nxt   = wr_en ? 2'h0 : key_r;
        if (wr_en && addr == ADDR_KEY) begin
            if (wr_data == KEY_FIRST) begin
                key_nxt = 2'h1;
            end else if (wr_data == KEY_SECOND && key_r == 2'h1) begin
                key_nxt = 2'h2;
            end
        end
        case (state_r)
            ST_IDLE: begin
                if (start_evt) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                cnt_nxt = 4'h0;
                if (ready) begin
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (new_edge) begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == WAIT_LAST) begin
                        state_nxt = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (fail_evt || sw_off) begin
            state_nxt = ST_IDLE;
        end
        // old source drops once current moves; keep-alives stay on
        oscen_nxt = src_osc(cur_r);
        pllen_nxt = src_pll(cur_r);
        if (state_r != ST_IDLE) begin
            oscen_nxt = oscen_nxt | src_osc(new_source_field_r);
            pllen_nxt = pllen_nxt | src_pll(new_source_field_r);
        end
        if (wdt_en || fail_safe_monitor_on) begin
            oscen_nxt[OSC_LOW_POWER_RC_OSC] = 1'b1;
        end
        if (secen_r) begin
            oscen_nxt[OSC_SEC] = 1'b1;
        end
        case (aclk_r[AUX_DIV_L +: 3])
            3'h7:    div_nxt = 4'h0;
            3'h6:    div_nxt = 4'h1;
            3'h5:    div_nxt = 4'h2;
            3'h4:    div_nxt = 4'h3;
            3'h3:    div_nxt = 4'h4;
            3'h2:    div_nxt = 4'h5;
            3'h1:    div_nxt = 4'h6;
            default: div_nxt = 4'h8;
        endcase
        rd_nxt = 16'h0000;
        if (rd_en) begin
            case (addr)
                ADDR_OSC_HI, ADDR_OSC_LO: begin
                    rd_nxt[CUR_LSB +: 3] = cur_r;
                    rd_nxt[NEW_LSB +: 3] = new_source_field_r;
                    rd_nxt[CLOCK_LOCK_BIT_B]    = clock_lock_bit_r;
                    rd_nxt[PLLLOCK_B]    = lock_r;
                    rd_nxt[CFAIL_B]      = cf_r;
                    rd_nxt[SECEN_B]      = secen_r;
                    rd_nxt[SWREQ_B]      = switch_request_bit_r & ~sw_off;
                end
                ADDR_ACLK: rd_nxt = aclk_r;
                default:   rd_nxt = 16'h0000;
            endcase
        end
    end

    // the processor is never held; all answers come in one cycle
    always_ff @(posedge core_clk) begin
        new_clk_d_r <= sync_b_r[3];
        if (srst || por_rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            key_r   <= 2'h0;
            trap_r  <= 1'b0;
            rd_r    <= 16'h0000;
            oscen_r <= 4'h1;
            pllen_r <= 1'b0;
            div_r   <= 4'h8;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            key_r   <= key_nxt;
            trap_r  <= trap_nxt;
            rd_r    <= rd_nxt;
            oscen_r <= oscen_nxt;
            pllen_r <= pllen_nxt;
            div_r   <= div_nxt;
        end
    end

    assign rd_data                = rd_r;
    assign sys_clk_sel            = cur_r;
    assign sys_pll_en             = pllen_r;
    assign osc_run_en             = oscen_r;
    assign clock_fail_trap        = trap_r;
    assign primary_submode        = submode_r;
    assign aux_divider_source_sel = aclk_r[AUX_SRC_B];
    assign aux_osc_type           = aclk_r[AUX_TYPE_L +: 2];
    assign aux_osc_enable         = aux_en_r;
    assign aux_div_log2           = div_r;
    assign aux_reference_sel      = aclk_r[AUX_REF_B];

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst || por_rst);

    request_held_a: assert property (sw_off |=> !switch_request_bit_r)
        else $error("switch request set while switching disabled");
    redundant_abort_a: assert property (
        state_r == ST_IDLE && switch_request_bit_r && redundant && !sw_off |=>
        !switch_request_bit_r && state_r == ST_IDLE)
        else $error("redundant switch not aborted");
    start_clear_a: assert property (start_evt |=> !cf_r && !lock_r && state_r == ST_WAIT)
        else $error("switch start did not clear flags");
    ten_edges_a: assert property (
        state_r == ST_COUNT && new_edge && cnt_r == WAIT_LAST && !fail_evt && !sw_off
        |=> state_r == ST_DONE)
        else $error("changeover not after counted new-clock edges");
    changeover_copy_a: assert property (
        state_r == ST_DONE && !fail_evt && !sw_off |=>
        cur_r == $past(new_source_field_r) && !switch_request_bit_r ##1 sys_clk_sel == cur_r)
        else $error("changeover did not copy source");
    fail_fallback_a: assert property (
        fail_evt && !sw_off |=> cf_r && clock_fail_trap && cur_osc[OSC_FRC]
        ##1 !clock_fail_trap || fail_evt)
        else $error("failure not handled");
    pll_fallback_a: assert property (fail_evt && src_pll(cur_r) |=> cur_r == SRC_FRC_PLL)
        else $error("pll fallback missing");
    locked_switch_a: assert property (clock_lock_bit_r && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("switch began while locked");
    unlock_block_a: assert property (
        wr_en && addr == ADDR_OSC_HI && key_r != 2'h2 |=> $stable(new_source_field_r))
        else $error("locked write changed new source");
    low_power_rc_osc_kept_a: assert property (fail_safe_monitor_on |=> ##1 osc_run_en[OSC_LOW_POWER_RC_OSC])
        else $error("low_power_rc_osc stopped under monitor");

    full_switch_c: cover property (state_r == ST_WAIT ##[1:200] state_r == ST_DONE);
    redundant_c: cover property (state_r == ST_IDLE && switch_request_bit_r && redundant);
    fail_c: cover property (fail_evt);
    unlock_write_c: cover property (wr_hi);

endmodule

// ### verif/clock_switch_fail_safe_bench.sv
// self-checking bench for the oscillator switch controller
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/100ps

module clock_switch_fail_safe_bench;
    import clk_switch_pkg::*;

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

    logic        core_clk, srst, por_rst, wr_en, rd_en, sw_cfg, pll_in, fail_in, nclk;
    logic [1:0]  addr;
    logic [15:0] wr_data, rd_data, d;
    logic [2:0]  sys_clk_sel, start_src;
    logic [3:0]  osc_run_en, aux_div_log2;
    logic [1:0]  aux_osc_type, psub;
    logic        sys_pll_en, trap, aux_src, aux_en, aux_ref;
    int          n_fail, check_count, i, edges, traps;
    // aux rows: written word and expected log2 of the divide
    logic [15:0] row_w [8] = '{16'h3F80, 16'h1600, 16'h2D80, 16'h0400,
                               16'h3B00, 16'h1280, 16'h2900, 16'h0080};
    logic [3:0]  row_div [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};

    clk_switch_fail_safe dut (
        .core_clk(core_clk), .srst(srst), .por_rst(por_rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .switching_config_bit(sw_cfg), .fail_safe_monitor_en(1'b1), .wdt_en(1'b0),
        .startup_source_config(start_src), .primary_submode_config(SUBMODE_EXT),
        .crystal_startup_timer_done(1'b0), .pll_locked_in(pll_in), .osc_fail_in(fail_in),
        .new_clk_in(nclk), .sys_clk_sel(sys_clk_sel), .sys_pll_en(sys_pll_en),
        .osc_run_en(osc_run_en), .clock_fail_trap(trap), .primary_submode(psub),
        .aux_divider_source_sel(aux_src), .aux_osc_enable(aux_en), .aux_osc_type(aux_osc_type),
        .aux_div_log2(aux_div_log2), .aux_reference_sel(aux_ref));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // strobe stays high across back-to-back writes; idle lowers it
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        addr <= a; wr_data <= v; wr_en <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic idle(input int n);
        wr_en <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // key pair must come directly before the guarded write
    task automatic uwr(input logic [1:0] a, input logic [15:0] v);
        wr(ADDR_KEY, KEY_FIRST); wr(ADDR_KEY, KEY_SECOND); wr(a, v); idle(1);
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        addr <= a; rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
        @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        n_fail = 0; check_count = 0;
        srst = 1'b1; por_rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 2'h0;
        wr_data = 16'h0000; sw_cfg = 1'b1; start_src = SRC_SEC; pll_in = 1'b0;
        fail_in = 1'b0; nclk = 1'b0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0; por_rst <= 1'b0;
        idle(4);
        `CHK("aux_div_por", 4'h8, aux_div_log2)
        // table rows: junk in unimplemented bits must read back as zero
        for (i = 0; i < 8; i++) begin
            wr(ADDR_ACLK, row_w[i] | 16'hC07F); idle(1);
            rd(ADDR_ACLK, d);
            `CHK("aux_read", row_w[i], d)
            `CHK("aux_src", row_w[i][13], aux_src)
            `CHK("aux_type", row_w[i][12:11], aux_osc_type)
            `CHK("aux_en", row_w[i][12:11] != 2'h0, aux_en)
            `CHK("aux_div", row_div[i], aux_div_log2)
            `CHK("aux_ref", row_w[i][7], aux_ref)
        end
        $display("test aux_rows done");
        // plain reset keeps the aux word, power-on reset clears it
        srst <= 1'b1; idle(1); srst <= 1'b0; idle(1);
        rd(ADDR_ACLK, d);
        `CHK("aux_keep", 16'h0080, d)
        por_rst <= 1'b1; idle(1); por_rst <= 1'b0; idle(3);
        rd(ADDR_ACLK, d);
        `CHK("aux_clear", ACLK_RESET, d)
        // switching disabled: request ignored, status follows startup config
        uwr(ADDR_OSC_HI, 16'h0500); uwr(ADDR_OSC_LO, 16'h0001); idle(5);
        rd(ADDR_OSC_LO, d);
        `CHK("req_dis", 1'b0, d[0])
        `CHK("cur_dis", SRC_SEC, d[14:12])
        `CHK("sel_dis", SRC_SEC, sys_clk_sel)
        $display("test disabled done");
        sw_cfg <= 1'b0; por_rst <= 1'b1; idle(1); por_rst <= 1'b0; idle(3);
        // request to the source already running is dropped
        uwr(ADDR_OSC_HI, 16'h0000); uwr(ADDR_OSC_LO, 16'h0001); idle(4);
        rd(ADDR_OSC_LO, d);
        `CHK("req_redundant", 1'b0, d[0])
        `CHK("sel_redundant", SRC_FRC, sys_clk_sel)
        // switch to primary with pll; holds until lock, then counts new clock edges
        uwr(ADDR_OSC_HI, 16'h0300); uwr(ADDR_OSC_LO, 16'h0001); idle(8);
        rd(ADDR_OSC_LO, d);
        `CHK("req_pending", 1'b1, d[0])
        `CHK("lock_clr", 1'b0, d[5])
        `CHK("sel_hold", SRC_FRC, sys_clk_sel)
        `CHK("pri_on", 1'b1, osc_run_en[OSC_PRI])
        pll_in <= 1'b1; idle(5);
        edges = 0;
        while (sys_clk_sel !== SRC_PRI_PLL) begin
            edges++;
            if (edges > 16) begin
                n_fail++;
                tally_and_finish;
            end
            nclk <= 1'b1; idle(4); nclk <= 1'b0; idle(4);
        end
        `CHK("new_edges", SWITCH_WAIT_CYCLES, edges)
        idle(3);
        `CHK("osc_after", 4'b1010, osc_run_en)
        `CHK("pll_en", 1'b1, sys_pll_en)
        `CHK("submode", SUBMODE_EXT, psub)
        rd(ADDR_OSC_LO, d);
        `CHK("cur_new", SRC_PRI_PLL, d[14:12])
        `CHK("req_done", 1'b0, d[0])
        `CHK("lock_set", 1'b1, d[5])
        $display("test switch done");
        // failure on a pll source: one trap, fallback to fast rc with pll
        fail_in <= 1'b1; traps = 0;
        for (i = 0; i < 10; i++) begin
            @(posedge core_clk);
            #1 if (trap === 1'b1) traps++;
        end
        `CHK("trap_once", 1, traps)
        `CHK("sel_fail", SRC_FRC_PLL, sys_clk_sel)
        fail_in <= 1'b0; idle(3);
        rd(ADDR_OSC_LO, d);
        `CHK("cf_set", 1'b1, d[3])
        uwr(ADDR_OSC_LO, 16'h0000);
        rd(ADDR_OSC_LO, d);
        `CHK("cf_clr", 1'b0, d[3])
        $display("test failure done");
        // unguarded write refused; lock freezes new field, selection stays put (request bit not read back)
        wr(ADDR_OSC_HI, 16'h0500); idle(1);
        rd(ADDR_OSC_HI, d);
        `CHK("no_key", SRC_PRI_PLL, d[10:8])
        uwr(ADDR_OSC_LO, 16'h0080); uwr(ADDR_OSC_HI, 16'h0500);
        uwr(ADDR_OSC_LO, 16'h0081); idle(20);
        rd(ADDR_OSC_LO, d);
        `CHK("new_locked", SRC_PRI_PLL, d[10:8])
        `CHK("lock_bit", 1'b1, d[7])
        `CHK("sel_locked", SRC_FRC_PLL, sys_clk_sel)
        $display("test lock done");
        tally_and_finish;
    end
endmodule
